/* File: src/bp_cpu_end.sv */
`timescale 1ns/1ps
`default_nettype none
module bp_cpu_end (
    input wire logic ref_clk,
    input wire logic reset,
    bp_if.dev bus,
    input wire logic req_valid,
    input wire bp_pkg::bp_kind_t req_kind,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_last,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic ei_exec,
    input wire logic di_exec,
    output logic int_taken,
    output logic halted,
    output logic [15:0] pc,
    output logic [7:0] ir,
    output logic rom_sel,
    output logic ram_sel,
    output logic disp_sel
);
    import bp_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    bp_state_t state_q;
    bp_state_t state_d;
    bp_kind_t kind_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic last_q;
    logic [7:0] stat_q;
    logic [7:0] stat_new;
    logic inte_q;
    logic halted_q;
    logic [15:0] pc_q;
    logic [7:0] ir_q;
    logic [7:0] rdata_q;
    logic rsp_valid_q;
    logic int_taken_q;
    logic rom_q;
    logic ram_q;
    logic disp_q;

    // ==========================================================
    // Decoding
    // ==========================================================
    wire start = (state_q == S_IDLE) && req_valid && req_ready;
    wire cyc_end = (state_q == S_T3);
    wire cyc_active = (state_q != S_IDLE) && (state_q != S_HOLD);
    wire is_mem_wr = (kind_q == BP_MEMWR) || (kind_q == BP_STKWR);
    wire is_wr = is_mem_wr || (kind_q == BP_IOWR);
    wire is_rd = (kind_q == BP_FETCH) || (kind_q == BP_MEMRD) || (kind_q == BP_IORD)
        || (kind_q == BP_INTA);
    wire in_hold = (state_q == S_HOLD);
    wire int_ok = bus.int_req && inte_q && !in_hold;
    wire at_instr_end = cyc_end && last_q;
    wire idle_halted = (state_q == S_IDLE) && halted_q && !bus.hold;
    wire accept_int = int_ok && (at_instr_end || idle_halted);
    wire dbin_int = (state_q == S_T2 || state_q == S_TW || cyc_end) && is_rd;
    wire wr_int = cyc_end && is_wr;
    wire [7:0] rd_mux = bus.dig1_n ? bus.di : bus.dio;
    wire dec_rom;
    wire dec_ram;
    wire dec_disp;

    assign req_ready = (state_q == S_IDLE) && !halted_q && !bus.hold;

    assign stat_new[SB_M1] = (req_kind == BP_FETCH);
    assign stat_new[SB_OUT] = (req_kind == BP_IOWR);
    assign stat_new[SB_INP] = (req_kind == BP_IORD);
    assign stat_new[SB_MEMR] = (req_kind == BP_FETCH) || (req_kind == BP_MEMRD);
    assign stat_new[SB_HLTA] = (req_kind == BP_HALT);
    assign stat_new[SB_WO] = (req_kind == BP_MEMWR) || (req_kind == BP_IOWR)
        || (req_kind == BP_STKWR);
    assign stat_new[SB_STACK] = (req_kind == BP_STKWR);
    assign stat_new[SB_INTA] = (req_kind == BP_INTA);

    bp_decode bp_decode_inst (
        .addr(req_addr),
        .rom_hit(dec_rom),
        .ram_hit(dec_ram),
        .disp_hit(dec_disp)
    );

    // ==========================================================
    // Bus drivers
    // ==========================================================
    assign bus.stat = stat_q;
    assign bus.stat_oe = !bus.stat_dsb;
    assign bus.cmd[CM_SYNC] = (state_q == S_T1);
    assign bus.cmd[CM_WR] = wr_int;
    assign bus.cmd[CM_DBIN] = dbin_int;
    assign bus.cmd[CM_HLDA] = in_hold;
    assign bus.cmd[CM_WAIT] = (state_q == S_TW) || halted_q;
    assign bus.cmd[CM_INTE] = inte_q;
    assign bus.cmd_oe = !bus.cc_dsb;
    assign bus.addr_o = addr_q;
    assign bus.addr_oe = !bus.add_dsb && !in_hold;
    assign bus.do_o = wdata_q;
    assign bus.do_oe = !bus.do_dsb && !in_hold;
    assign bus.dio_o = wdata_q;
    assign bus.dio_oe = cyc_active && !bus.do_dsb && !(dbin_int && !bus.dig1_n);
    assign bus.pdbins = dbin_int && bus.dig1_n;
    assign bus.mwrite = wr_int && is_mem_wr;
    assign bus.mwrite_oe = bus.frdy;

    // ==========================================================
    // Machine cycle sequencer
    // ==========================================================
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (bus.hold) begin
                    state_d = S_HOLD;
                end else if (start) begin
                    state_d = S_T1;
                end
            end
            S_T1: begin
                state_d = S_T2;
            end
            S_T2: begin
                state_d = bus.prdy ? S_T3 : S_TW;
            end
            S_TW: begin
                if (bus.prdy) begin
                    state_d = S_T3;
                end
            end
            S_T3: begin
                state_d = bus.hold ? S_HOLD : S_IDLE;
            end
            S_HOLD: begin
                if (!bus.hold) begin
                    state_d = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle context is captured when the cycle is accepted and held to its end.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            kind_q <= BP_FETCH;
            addr_q <= PC_RESET;
            wdata_q <= 8'h00;
            last_q <= 1'b0;
            stat_q <= 8'h00;
        end else if (start) begin
            kind_q <= req_kind;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            last_q <= req_last;
            stat_q <= stat_new;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rom_q <= 1'b0;
            ram_q <= 1'b0;
            disp_q <= 1'b0;
        end else if (start) begin
            rom_q <= dec_rom;
            ram_q <= dec_ram;
            disp_q <= dec_disp;
        end
    end

    // ==========================================================
    // Read data, program counter and instruction register
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rsp_valid_q <= 1'b0;
            pc_q <= PC_RESET;
            ir_q <= IR_RESET;
        end else begin
            rsp_valid_q <= cyc_end;
            if (cyc_end && is_rd) begin
                rdata_q <= rd_mux;
            end
            if (cyc_end && kind_q == BP_FETCH) begin
                ir_q <= rd_mux;
                pc_q <= addr_q + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Interrupt enable and halt
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            inte_q <= 1'b0;
            halted_q <= 1'b0;
            int_taken_q <= 1'b0;
        end else begin
            int_taken_q <= accept_int;
            if (accept_int || di_exec) begin
                inte_q <= 1'b0;
            end else if (ei_exec) begin
                inte_q <= 1'b1;
            end
            if (accept_int) begin
                halted_q <= 1'b0;
            end else if (cyc_end && kind_q == BP_HALT) begin
                halted_q <= 1'b1;
            end
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rdata_q;
    assign int_taken = int_taken_q;
    assign halted = halted_q;
    assign pc = pc_q;
    assign ir = ir_q;
    assign rom_sel = rom_q;
    assign ram_sel = ram_q;
    assign disp_sel = disp_q;
endmodule
`default_nettype wire

/* File: inc/bp_pkg.sv */
// Contract
// - Status/command disable lines float those drivers.
// - Address/data-out disable lines float those drivers.
// - Hold: finish cycle, acknowledge, release buses.
// - Interrupt-enable output mirrors internal enable flop.
// - Interrupt sampled at instruction end or halted.
// - Interrupt ignored in hold or when disabled.
// - Requester waits for acknowledge before taking buses.
// - Reset clears program counter and instruction register.
// - Sync pulses at start of every machine cycle.
// - Write strobe for memory/output, data held stable.
// - Data-bus-in asserted whenever reading external data.
// - Machine-cycle-one status only in opcode fetch.
// - Output status during I/O write cycles.
// - Input status; addressed board drives during data-bus-in.
// - Memory-read status for memory read cycles.
// - Halt-acknowledge status after halt instruction.
// - Write-out status for memory write or output.
// - Input gate low: reroute input, gate drivers.
// - Front-panel ready low disables memory-write driver.
// - Memory write marks data-out for storing.
// - Ready low from boards inserts wait states.
// - Decode on-card ROM, system RAM, display RAM.
package bp_pkg;

    // ==========================================================
    // On-card memory map and board window
    // ==========================================================
    localparam logic [15:0] ROM_BASE = 16'hC000;
    localparam logic [15:0] ROM_LAST = 16'hC7FF;
    localparam logic [15:0] RAM_BASE = 16'hC800;
    localparam logic [15:0] RAM_LAST = 16'hCBFF;
    localparam logic [15:0] DISP_BASE = 16'hCC00;
    localparam logic [15:0] DISP_LAST = 16'hCFFF;
    localparam logic [7:0] BRD_MEM_PAGE = 8'h00;
    localparam logic [7:0] BRD_IO_PORT = 8'h10;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] IR_RESET = 8'h00;
    localparam logic [7:0] BUS_IDLE = 8'hFF;

    // ==========================================================
    // Status and command bit positions
    // ==========================================================
    localparam int SB_M1 = 0;
    localparam int SB_OUT = 1;
    localparam int SB_INP = 2;
    localparam int SB_MEMR = 3;
    localparam int SB_HLTA = 4;
    localparam int SB_WO = 5;
    localparam int SB_STACK = 6;
    localparam int SB_INTA = 7;
    localparam int CM_SYNC = 0;
    localparam int CM_WR = 1;
    localparam int CM_DBIN = 2;
    localparam int CM_HLDA = 3;
    localparam int CM_WAIT = 4;
    localparam int CM_INTE = 5;

    typedef enum logic [2:0] {
        BP_FETCH, BP_MEMRD, BP_MEMWR, BP_IORD, BP_IOWR, BP_HALT, BP_INTA, BP_STKWR
    } bp_kind_t;

    typedef enum {S_IDLE, S_T1, S_T2, S_TW, S_T3, S_HOLD} bp_state_t;

endpackage

/* File: inc/bp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bp_if;
    logic [15:0] addr_o;
    logic addr_oe;
    logic [7:0] do_o;
    logic do_oe;
    logic [7:0] dio_o;
    logic dio_oe;
    logic [7:0] stat;
    logic stat_oe;
    logic [5:0] cmd;
    logic cmd_oe;
    logic mwrite;
    logic mwrite_oe;
    logic pdbins;
    logic stat_dsb;
    logic cc_dsb;
    logic add_dsb;
    logic do_dsb;
    logic hold;
    logic int_req;
    logic prdy;
    logic dig1_n;
    logic frdy;
    logic [7:0] di_o;
    logic di_oe;
    logic [7:0] dio_b;
    logic dio_b_oe;
    logic [7:0] di;
    logic [7:0] dio;

    // Undriven data lines read as the pulled-up idle level.
    assign di = di_oe ? di_o : bp_pkg::BUS_IDLE;
    assign dio = dio_oe ? dio_o : (dio_b_oe ? dio_b : bp_pkg::BUS_IDLE);

    modport dev (
        output addr_o, addr_oe, do_o, do_oe, dio_o, dio_oe, stat, stat_oe,
        output cmd, cmd_oe, mwrite, mwrite_oe, pdbins,
        input stat_dsb, cc_dsb, add_dsb, do_dsb, hold, int_req, prdy, dig1_n, frdy,
        input di, dio
    );
    modport brd (
        input addr_o, do_o, stat, cmd, mwrite, mwrite_oe, pdbins, dio,
        output stat_dsb, cc_dsb, add_dsb, do_dsb, hold, int_req, prdy, dig1_n, frdy,
        output di_o, di_oe, dio_b, dio_b_oe
    );
endinterface
`default_nettype wire

/* File: src/bp_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module bp_decode (
    input wire logic [15:0] addr,
    output logic rom_hit,
    output logic ram_hit,
    output logic disp_hit
);
    import bp_pkg::*;

    assign rom_hit = (addr >= ROM_BASE) && (addr <= ROM_LAST);
    assign ram_hit = (addr >= RAM_BASE) && (addr <= RAM_LAST);
    assign disp_hit = (addr >= DISP_BASE) && (addr <= DISP_LAST);
endmodule
`default_nettype wire

/* File: src/bp_board_end.sv */
`timescale 1ns/1ps
`default_nettype none
module bp_board_end (
    input wire logic ref_clk,
    input wire logic reset,
    bp_if.brd bus,
    input wire logic [3:0] stretch,
    input wire logic hold_req,
    input wire logic int_in,
    input wire logic stat_dis,
    input wire logic cmd_dis,
    input wire logic addr_dis,
    input wire logic dout_dis,
    input wire logic gate_dio,
    input wire logic panel_ready,
    input wire logic [7:0] io_in_data,
    output logic hold_granted,
    output logic [7:0] io_out_data,
    output logic io_out_valid
);
    import bp_pkg::*;

    // ==========================================================
    // Cycle capture
    // ==========================================================
    logic [7:0] mem_q [0:255];
    logic mem_hit_q;
    logic io_hit_q;
    logic [7:0] rd_q;
    logic [7:0] waddr_q;
    logic [3:0] wcnt_q;
    logic [7:0] io_out_q;
    logic io_out_valid_q;

    wire sync = bus.cmd[CM_SYNC];
    wire mem_cyc = bus.stat[SB_MEMR] || (bus.stat[SB_WO] && !bus.stat[SB_OUT]);
    wire io_cyc = bus.stat[SB_INP] || bus.stat[SB_OUT];
    wire mem_hit = mem_cyc && (bus.addr_o[15:8] == BRD_MEM_PAGE);
    wire io_hit = io_cyc && (bus.addr_o[7:0] == BRD_IO_PORT);
    wire any_hit = mem_hit_q || io_hit_q;
    wire reading = bus.cmd[CM_DBIN] && any_hit;
    wire mem_store = bus.mwrite && bus.mwrite_oe && mem_hit_q;
    wire io_store = bus.cmd[CM_WR] && io_hit_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_hit_q <= 1'b0;
            io_hit_q <= 1'b0;
            rd_q <= 8'h00;
            waddr_q <= 8'h00;
            wcnt_q <= 4'h0;
        end else if (sync) begin
            mem_hit_q <= mem_hit;
            io_hit_q <= io_hit;
            waddr_q <= bus.addr_o[7:0];
            rd_q <= bus.stat[SB_INP] ? io_in_data : mem_q[bus.addr_o[7:0]];
            wcnt_q <= (mem_hit || io_hit) ? stretch : 4'h0;
        end else if (wcnt_q != 4'h0) begin
            wcnt_q <= wcnt_q - 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_store) begin
            mem_q[waddr_q] <= bus.do_o;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            io_out_q <= 8'h00;
            io_out_valid_q <= 1'b0;
        end else begin
            io_out_valid_q <= io_store;
            if (io_store) begin
                io_out_q <= bus.do_o;
            end
        end
    end

    // ==========================================================
    // Bus drive
    // ==========================================================
    assign bus.prdy = (wcnt_q == 4'h0);
    assign bus.di_o = rd_q;
    assign bus.di_oe = reading && !gate_dio;
    assign bus.dio_b = rd_q;
    assign bus.dio_b_oe = reading && gate_dio;
    assign bus.dig1_n = !gate_dio;
    assign bus.hold = hold_req;
    assign bus.int_req = int_in;
    assign bus.stat_dsb = stat_dis;
    assign bus.cc_dsb = cmd_dis;
    assign bus.add_dsb = addr_dis;
    assign bus.do_dsb = dout_dis;
    assign bus.frdy = panel_ready;
    assign hold_granted = hold_req && bus.cmd[CM_HLDA];
    assign io_out_data = io_out_q;
    assign io_out_valid = io_out_valid_q;
endmodule
`default_nettype wire

/* File: sim/bp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module bp_assertions (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic addr_oe,
    input wire logic [7:0] do_o,
    input wire logic do_oe,
    input wire logic [7:0] dio_o,
    input wire logic [7:0] stat,
    input wire logic stat_oe,
    input wire logic [5:0] cmd,
    input wire logic cmd_oe,
    input wire logic mwrite,
    input wire logic mwrite_oe,
    input wire logic pdbins,
    input wire logic stat_dsb,
    input wire logic cc_dsb,
    input wire logic add_dsb,
    input wire logic do_dsb,
    input wire logic prdy,
    input wire logic dig1_n,
    input wire logic frdy
);
    import bp_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Driver release
    // ==========================================================
    a_stat_float: assert property (stat_oe == !stat_dsb)
        else $error("status drivers not released");
    a_cmd_float: assert property (cmd_oe == !cc_dsb)
        else $error("command drivers not released");
    a_addr_float: assert property (add_dsb ##1 add_dsb |-> !addr_oe)
        else $error("address drivers not released");
    a_dout_float: assert property (do_dsb ##1 do_dsb |-> !do_oe)
        else $error("data out drivers not released");
    a_hold_release: assert property (cmd[CM_HLDA] |-> !addr_oe && !do_oe)
        else $error("buses driven in hold");

    // ==========================================================
    // Cycle strobes and status
    // ==========================================================
    a_sync_pulse: assert property (cmd[CM_SYNC] |=> !cmd[CM_SYNC] [*3])
        else $error("sync not a single pulse per cycle");
    a_stat_held: assert property (cmd[CM_SYNC] |=> $stable(stat) [*2])
        else $error("status moved within cycle");
    a_wr_stable: assert property (cmd[CM_WR] |-> $stable(dio_o) && $stable(do_o) && stat[SB_WO])
        else $error("write data moved under strobe");
    a_dbin_read: assert property (cmd[CM_DBIN] |-> !stat[SB_WO] && !cmd[CM_WR])
        else $error("data in during write cycle");
    a_m1_fetch: assert property (stat[SB_M1] |-> !stat[SB_WO] && !stat[SB_OUT])
        else $error("first cycle status on write");
    a_out_io: assert property (stat[SB_OUT] |-> !stat[SB_MEMR] && !stat[SB_INP])
        else $error("output status mixed");
    a_pdbins_gate: assert property (pdbins == (cmd[CM_DBIN] && dig1_n))
        else $error("buffered data in not gated");
    a_mwrite_strobe: assert property (mwrite |-> cmd[CM_WR] && stat[SB_WO] && !stat[SB_OUT])
        else $error("memory write outside memory write");
    a_frdy_gate: assert property (mwrite_oe == frdy)
        else $error("memory write driver not gated");
    a_wait_ready: assert property (cmd[CM_SYNC] ##1 !prdy |=> cmd[CM_WAIT])
        else $error("no wait state on ready low");

    c_wait: cover property (cmd[CM_WAIT] && !stat[SB_HLTA]);
    c_hold: cover property (cmd[CM_HLDA]);
    c_gate: cover property (cmd[CM_DBIN] && !dig1_n);
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import bp_pkg::*;
    logic ref_clk, reset, req_valid, req_last, req_ready, rsp_valid, ei_exec, di_exec;
    logic int_taken, halted, rom_sel, ram_sel, disp_sel, hold_req, int_in, stat_dis;
    logic cmd_dis, addr_dis, dout_dis, gate_dio, panel_ready, hold_granted, io_out_valid;
    logic dbin_seen, wr_seen, mw_seen;
    bp_kind_t req_kind;
    logic [15:0] req_addr, pc;
    logic [7:0] req_wdata, rsp_data, ir, io_in_data, io_out_data, st, rd;
    logic [3:0] stretch;
    int n_errors = 0;
    int cmp_count = 0;
    int n_int = 0;
    localparam int CYC_LAT = 4;
    bp_kind_t kk [7] = '{BP_FETCH, BP_MEMRD, BP_MEMWR, BP_IORD, BP_IOWR, BP_STKWR, BP_INTA};
    logic [15:0] ka [7] = '{16'h0000, 16'h0040, 16'h0020, 16'h1010, 16'h1010, 16'h00F0, 16'hF000};
    logic [15:0] da [8] = '{16'hC000, 16'hC7FF, 16'hC800, 16'hCBFF, 16'hCC00, 16'hCFFF,
        16'hBFFF, 16'hD000};
    logic [2:0] de [8] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};

    bp_if bus_if ();
    bp_cpu_end bp_cpu_end_inst (.ref_clk(ref_clk), .reset(reset), .bus(bus_if.dev),
        .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_last(req_last), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ei_exec(ei_exec), .di_exec(di_exec),
        .int_taken(int_taken), .halted(halted), .pc(pc), .ir(ir), .rom_sel(rom_sel),
        .ram_sel(ram_sel), .disp_sel(disp_sel));
    bp_board_end bp_board_end_inst (.ref_clk(ref_clk), .reset(reset), .bus(bus_if.brd),
        .stretch(stretch), .hold_req(hold_req), .int_in(int_in), .stat_dis(stat_dis),
        .cmd_dis(cmd_dis), .addr_dis(addr_dis), .dout_dis(dout_dis), .gate_dio(gate_dio),
        .panel_ready(panel_ready), .io_in_data(io_in_data), .hold_granted(hold_granted),
        .io_out_data(io_out_data), .io_out_valid(io_out_valid));
    bp_assertions bp_assertions_inst (.ref_clk(ref_clk), .reset(reset),
        .addr_oe(bus_if.addr_oe), .do_o(bus_if.do_o), .do_oe(bus_if.do_oe),
        .dio_o(bus_if.dio_o), .stat(bus_if.stat), .stat_oe(bus_if.stat_oe),
        .cmd(bus_if.cmd), .cmd_oe(bus_if.cmd_oe), .mwrite(bus_if.mwrite),
        .mwrite_oe(bus_if.mwrite_oe), .pdbins(bus_if.pdbins), .stat_dsb(bus_if.stat_dsb),
        .cc_dsb(bus_if.cc_dsb), .add_dsb(bus_if.add_dsb), .do_dsb(bus_if.do_dsb),
        .prdy(bus_if.prdy), .dig1_n(bus_if.dig1_n), .frdy(bus_if.frdy));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (!reset && int_taken !== 1'b0) n_int <= n_int + 1;
    end

    // ==========================================================
    // Bus cycle tasks
    // ==========================================================
    function automatic logic [15:0] stx(input bp_kind_t k);
        logic [7:0] e;
        logic [7:0] m;
        m = 8'hFF;
        case (k)
            BP_FETCH: e = (8'h01 << SB_M1) | (8'h01 << SB_MEMR);
            BP_MEMRD: e = 8'h01 << SB_MEMR;
            BP_MEMWR: e = 8'h01 << SB_WO;
            BP_IORD: e = 8'h01 << SB_INP;
            BP_IOWR: e = (8'h01 << SB_OUT) | (8'h01 << SB_WO);
            BP_STKWR: e = (8'h01 << SB_STACK) | (8'h01 << SB_WO);
            BP_HALT: begin
                e = 8'h01 << SB_HLTA;
                m = e;
            end
            default: begin
                e = 8'h01 << SB_INTA;
                m = e;
            end
        endcase
        return {m, e};
    endfunction

    // Holds the request until ready is seen, then watches the wire until the answer.
    task automatic cyc(input bp_kind_t k, input logic [15:0] a, input logic [7:0] w,
        input logic l, input int ws);
        logic [15:0] sm;
        logic rk;
        int n;
        rk = (k == BP_FETCH || k == BP_MEMRD || k == BP_IORD || k == BP_INTA);
        sm = stx(k);
        dbin_seen = 1'b0;
        wr_seen = 1'b0;
        mw_seen = 1'b0;
        st = 8'h00;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_addr <= a;
        req_wdata <= w;
        req_last <= l;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 64);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (bus_if.cmd[CM_SYNC] === 1'b1) st = bus_if.stat;
            dbin_seen |= bus_if.cmd[CM_DBIN];
            wr_seen |= bus_if.cmd[CM_WR];
            mw_seen |= bus_if.mwrite;
        end while (rsp_valid !== 1'b1 && n < 64);
        rd = rsp_data;
        `CHK(n, CYC_LAT + ws)
        `CHK(st & sm[15:8], sm[7:0])
        if (k != BP_HALT) begin
            `CHK({dbin_seen, wr_seen, mw_seen}, {rk, !rk, k == BP_MEMWR || k == BP_STKWR})
        end
    endtask

    task automatic pulse(input logic en);
        @(posedge ref_clk);
        ei_exec <= en;
        di_exec <= !en;
        @(posedge ref_clk);
        ei_exec <= 1'b0;
        di_exec <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        give_verdict;
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_kind = BP_FETCH;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        req_last = 1'b0;
        ei_exec = 1'b0;
        di_exec = 1'b0;
        stretch = 4'h0;
        hold_req = 1'b0;
        int_in = 1'b0;
        stat_dis = 1'b0;
        cmd_dis = 1'b0;
        addr_dis = 1'b0;
        dout_dis = 1'b0;
        gate_dio = 1'b0;
        panel_ready = 1'b1;
        io_in_data = 8'hC3;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        `CHK({pc, ir, bus_if.cmd[CM_INTE]}, {PC_RESET, IR_RESET, 1'b0})
        for (int i = 0; i < 7; i++) begin
            cyc(kk[i], ka[i], 8'h5A, 1'b0, 0);
            if (kk[i] == BP_IORD) `CHK(rd, 8'hC3)
            if (kk[i] == BP_IOWR) `CHK(io_out_valid, 1'b1)
        end
        `CHK(io_out_data, 8'h5A)
        @(posedge ref_clk);
        stretch <= 4'hF;
        gate_dio <= 1'b1;
        cyc(BP_IORD, 16'h1010, 8'h00, 1'b0, 15);
        `CHK(rd, 8'hC3)
        @(posedge ref_clk);
        stretch <= 4'h1;
        gate_dio <= 1'b0;
        cyc(BP_MEMWR, 16'h0030, 8'h3C, 1'b0, 1);
        cyc(BP_MEMRD, 16'h0030, 8'h00, 1'b0, 1);
        `CHK(rd, 8'h3C)
        @(posedge ref_clk);
        stretch <= 4'h0;
        {panel_ready, stat_dis, cmd_dis, addr_dis, dout_dis} <= 5'h0F;
        repeat (2) @(negedge ref_clk);
        `CHK({bus_if.mwrite_oe, bus_if.stat_oe, bus_if.cmd_oe, bus_if.addr_oe, bus_if.do_oe}, 5'h00)
        @(posedge ref_clk);
        {panel_ready, stat_dis, cmd_dis, addr_dis, dout_dis} <= 5'h10;
        pulse(1'b1);
        `CHK(bus_if.cmd[CM_INTE], 1'b1)
        @(posedge ref_clk);
        int_in <= 1'b1;
        cyc(BP_MEMRD, 16'hC000, 8'h00, 1'b0, 0);
        `CHK(n_int, 0)
        cyc(BP_MEMRD, 16'hC001, 8'h00, 1'b1, 0);
        repeat (2) @(negedge ref_clk);
        `CHK({n_int[3:0], bus_if.cmd[CM_INTE]}, 5'h02)
        pulse(1'b1);
        pulse(1'b0);
        `CHK(bus_if.cmd[CM_INTE], 1'b0)
        cyc(BP_MEMRD, 16'hC002, 8'h00, 1'b1, 0);
        repeat (2) @(negedge ref_clk);
        `CHK(n_int, 1)
        pulse(1'b1);
        @(posedge ref_clk);
        int_in <= 1'b0;
        cyc(BP_HALT, 16'h0050, 8'h00, 1'b1, 0);
        @(negedge ref_clk);
        `CHK(halted, 1'b1)
        @(posedge ref_clk);
        int_in <= 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK({n_int[3:0], halted}, 5'h04)
        pulse(1'b1);
        fork
            cyc(BP_IORD, 16'h1010, 8'h00, 1'b0, 0);
            begin
                repeat (2) @(posedge ref_clk);
                hold_req <= 1'b1;
            end
        join
        `CHK(rd, 8'hC3)
        repeat (2) @(negedge ref_clk);
        `CHK({hold_granted, bus_if.cmd[CM_HLDA], bus_if.addr_oe, bus_if.do_oe, req_ready}, 5'h18)
        `CHK(n_int, 2)
        @(posedge ref_clk);
        int_in <= 1'b0;
        hold_req <= 1'b0;
        cyc(BP_HALT, 16'h0050, 8'h00, 1'b1, 0);
        @(posedge ref_clk);
        {hold_req, int_in} <= 2'h3;
        repeat (3) @(negedge ref_clk);
        `CHK({n_int[3:0], halted, bus_if.cmd[CM_HLDA]}, 6'h0B)
        @(posedge ref_clk);
        hold_req <= 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK({n_int[3:0], halted}, 5'h06)
        @(posedge ref_clk);
        int_in <= 1'b0;
        pulse(1'b1);
        for (int i = 0; i < 8; i++) begin
            cyc(BP_MEMRD, da[i], 8'h00, 1'b0, 0);
            `CHK({rom_sel, ram_sel, disp_sel}, de[i])
        end
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK({pc, ir, bus_if.cmd[CM_INTE]}, {PC_RESET, IR_RESET, 1'b0})
        @(posedge ref_clk);
        reset <= 1'b0;
        give_verdict;
    end
endmodule
`default_nettype wire
